// File: design/bbs_decode_exec.sv
// Decode and execute of relative branches and single-bit set
`timescale 1ns/1ps
`default_nettype none
module bbs_decode_exec
	import bbs_pkg::*;
#(
	parameter int PC_W = 21
) (
	// Clock and reset
	input  wire logic              i_core_clk,
	input  wire logic              i_reset_n,
	// Instruction issue
	input  wire logic              i_instr_valid,
	input  wire logic [15:0]       i_instr,
	input  wire logic [PC_W-1:0]   i_instr_pc,
	output logic                   o_instr_ready,
	output logic                   o_flush,
	// Status flags and bank select
	input  wire logic              i_flag_ovf,
	input  wire logic              i_flag_zero,
	input  wire logic [BANK_W-1:0] i_bank_select,
	// Program counter load
	output logic                   o_pc_load,
	output logic [PC_W-1:0]        o_pc_target,
	// Data memory
	output logic                   o_mem_rd,
	output logic                   o_mem_wr,
	output logic [11:0]            o_mem_addr,
	output logic [7:0]             o_mem_wdata,
	input  wire logic [7:0]        i_mem_rdata
);
	// =========================================================
	// Phase generator
	bbs_phase_if ph ();

	bbs_qphase u_qphase (
		.i_core_clk (i_core_clk),
		.i_reset_n  (i_reset_n),
		.ph         (ph)
	);

	// =========================================================
	// Decode
	bbs_op_e    op_ff;
	bbs_op_e    dec_op;
	bbs_state_e state_ff;
	logic [15:0]       instr_ff;
	logic [PC_W-1:0]   pc_ff;
	logic              take_ff;
	logic [PC_W-1:0]   target_ff;
	logic [11:0]       addr_ff;
	logic [7:0]        wdata_ff;

	wire logic             is_no_ovf  = (i_instr[OPC8_HI:OPC8_LO] == OPC_NO_OVF);
	wire logic             is_nonzero = (i_instr[OPC8_HI:OPC8_LO] == OPC_NONZERO);
	wire logic             is_always  = (i_instr[OPC8_HI:OPC5_LO] == OPC_ALWAYS_REL);
	wire logic             is_set_bit = (i_instr[OPC8_HI:OPC4_LO] == OPC_SET_BIT);
	wire logic             accept     = ph.q1 && (state_ff == ST_RUN) && i_instr_valid;
	wire logic [7:0]       file_addr  = i_instr[7:0];

	// Access bank straddles the low and high ends of data memory
	wire logic             acc_high   = (file_addr >= ACCESS_SPLIT);
	wire logic [BANK_W-1:0] acc_bank  = acc_high ? ACCESS_HI_BANK : ACCESS_LO_BANK;
	wire logic [BANK_W-1:0] sel_bank  = i_instr[ACC_FLAG] ? i_bank_select : acc_bank;

	assign dec_op = is_no_ovf  ? OP_NO_OVF  :
	                is_nonzero ? OP_NONZERO :
	                is_always  ? OP_ALWAYS  :
	                is_set_bit ? OP_SET_BIT : OP_NONE;

	// =========================================================
	// Branch target and condition
	wire logic [PC_W-1:0] ofs_short = {{(PC_W-SHORT_W-1){instr_ff[SHORT_W-1]}}, instr_ff[SHORT_W-1:0], 1'b0};
	wire logic [PC_W-1:0] ofs_long  = {{(PC_W-LONG_W-1){instr_ff[LONG_W-1]}}, instr_ff[LONG_W-1:0], 1'b0};
	wire logic [PC_W-1:0] ofs2      = (op_ff == OP_ALWAYS) ? ofs_long : ofs_short;
	wire logic [PC_W-1:0] sum_tgt   = pc_ff + PC_W'(PC_STEP) + ofs2;
	// Low bit forced clear so a stray odd PC never yields a misaligned fetch
	wire logic [PC_W-1:0] nxt_target_ff = {sum_tgt[PC_W-1:1], 1'b0};

	logic nxt_take_ff;
	always_comb begin
		case (op_ff)
			OP_NO_OVF:  nxt_take_ff = !i_flag_ovf;
			OP_NONZERO: nxt_take_ff = !i_flag_zero;
			OP_ALWAYS:  nxt_take_ff = 1'b1;
			default:    nxt_take_ff = 1'b0;
		endcase
	end

	// =========================================================
	// Bit set data path
	wire logic [2:0] bit_idx   = instr_ff[BIT_IDX_HI:BIT_IDX_LO];
	wire logic [7:0] nxt_wdata_ff = i_mem_rdata | (8'h01 << bit_idx);

	// =========================================================
	// Sequencing
	wire logic run = (state_ff == ST_RUN);

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			op_ff    <= OP_NONE;
			instr_ff <= 16'h0000;
			pc_ff    <= '0;
			addr_ff  <= 12'h000;
		end else if (ph.q1 && run) begin
			op_ff    <= accept ? dec_op : OP_NONE;
			instr_ff <= i_instr;
			pc_ff    <= i_instr_pc;
			addr_ff  <= {sel_bank, file_addr};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			take_ff   <= 1'b0;
			target_ff <= '0;
			wdata_ff  <= 8'h00;
		end else if (ph.q3 && run) begin
			take_ff   <= nxt_take_ff;
			target_ff <= nxt_target_ff;
			if (op_ff == OP_SET_BIT)
				wdata_ff <= nxt_wdata_ff;
		end
	end

	// Taken branch discards the prefetched word by idling one full cycle
	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			state_ff <= ST_RUN;
		else if (ph.q4)
			state_ff <= (run && take_ff) ? ST_FLUSH : ST_RUN;
	end

	// =========================================================
	// Outputs
	assign o_instr_ready = ph.q1 && run;
	assign o_flush       = !run;
	assign o_pc_load     = ph.q4 && run && take_ff;
	assign o_pc_target   = target_ff;
	assign o_mem_rd      = ph.q2 && run && (op_ff == OP_SET_BIT);
	assign o_mem_wr      = ph.q4 && run && (op_ff == OP_SET_BIT);
	assign o_mem_addr    = addr_ff;
	assign o_mem_wdata   = wdata_ff;

	// =========================================================
	// Assertions
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);

	no_ovf_take_a: assert property (ph.q3 && run && op_ff == OP_NO_OVF |=> o_pc_load == !$past(i_flag_ovf))
		else $error("overflow-clear branch decision wrong");
	nonzero_take_a: assert property (ph.q3 && run && op_ff == OP_NONZERO |=> o_pc_load == !$past(i_flag_zero))
		else $error("zero-clear branch decision wrong");
	short_target_a: assert property (o_pc_load && op_ff != OP_ALWAYS |->
		o_pc_target == pc_ff + PC_W'(PC_STEP) + ofs_short)
		else $error("short branch target wrong");
	untaken_one_a: assert property (ph.q4 && run && !o_pc_load |=> o_instr_ready)
		else $error("untaken branch did not finish in one cycle");
	long_target_a: assert property (o_pc_load && op_ff == OP_ALWAYS |->
		o_pc_target == pc_ff + PC_W'(PC_STEP) + ofs_long)
		else $error("long branch target wrong");
	taken_two_a: assert property (o_pc_load |=> (!o_instr_ready && o_flush)[*4] ##1 o_instr_ready)
		else $error("taken branch not followed by one idle cycle");
	always_taken_a: assert property (ph.q3 && run && op_ff == OP_ALWAYS |=> o_pc_load)
		else $error("unconditional branch not taken");
	set_bit_rmw_a: assert property (o_mem_rd |-> ##2 (o_mem_wr && o_mem_wdata[bit_idx]
		&& o_mem_addr == $past(o_mem_addr, 2)))
		else $error("bit set write-back wrong");
	set_keep_a: assert property (o_mem_rd ##1 1'b1 |=> o_mem_wdata == ($past(i_mem_rdata) | (8'h01 << bit_idx)))
		else $error("bit set changed other bits");
	access_bank_a: assert property (o_mem_rd && !instr_ff[ACC_FLAG] |->
		o_mem_addr[11:8] == (instr_ff[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK))
		else $error("access bank address wrong");
	even_target_a: assert property (o_pc_load |-> !o_pc_target[0])
		else $error("odd branch target");

	// =========================================================
	// Decode checks: the word taken at Q1 picks the operation
	dec_no_ovf_a: assert property (accept && i_instr[OPC8_HI:OPC8_LO] == OPC_NO_OVF
		|=> op_ff == OP_NO_OVF)
		else $error("overflow-clear branch not decoded");
	dec_nonzero_a: assert property (accept && i_instr[OPC8_HI:OPC8_LO] == OPC_NONZERO
		|=> op_ff == OP_NONZERO)
		else $error("zero-clear branch not decoded");
	dec_always_a: assert property (accept && i_instr[OPC8_HI:OPC5_LO] == OPC_ALWAYS_REL
		|=> op_ff == OP_ALWAYS)
		else $error("unconditional branch not decoded");
	dec_set_bit_a: assert property (accept && i_instr[OPC8_HI:OPC4_LO] == OPC_SET_BIT
		|=> op_ff == OP_SET_BIT)
		else $error("bit set not decoded");

	// =========================================================
	// Cycle framing and quiet periods
	ready_spacing_a: assert property (o_instr_ready |=> (!o_instr_ready)[*3])
		else $error("instruction cycle shorter than four clocks");
	flush_quiet_a: assert property (o_flush |-> !o_pc_load && !o_mem_rd && !o_mem_wr)
		else $error("activity during flush cycle");
	unknown_nop_a: assert property (ph.q4 && run && op_ff == OP_NONE |-> !o_pc_load && !o_mem_wr)
		else $error("unknown opcode did not idle");
	set_one_cycle_a: assert property (o_mem_wr |=> o_instr_ready && !o_flush)
		else $error("bit set took more than one cycle");

	// =========================================================
	// Bit set addressing
	file_addr_a: assert property (o_mem_rd |-> o_mem_addr[7:0] == instr_ff[7:0])
		else $error("bit set file address wrong");
	// Bank select is taken with the word, so a later change cannot redirect this access
	bank_select_a: assert property (o_mem_rd && instr_ff[ACC_FLAG] |->
		o_mem_addr[11:8] == $past(i_bank_select))
		else $error("banked access ignored bank select");

	cov_no_ovf_c: cover property (o_pc_load && op_ff == OP_NO_OVF);
	cov_nz_skip_c: cover property (ph.q4 && run && op_ff == OP_NONZERO && !take_ff);
	cov_always_c: cover property (o_pc_load && op_ff == OP_ALWAYS);
	cov_set_bit_c: cover property (o_mem_wr && instr_ff[ACC_FLAG]);
	cov_nz_take_c: cover property (o_pc_load && op_ff == OP_NONZERO);
endmodule
`default_nettype wire

// File: design/bbs_pkg.sv
// Shared constants for the branch and bit-set decode/execute block
package bbs_pkg;

	// =========================================================
	// Opcode matching
	localparam logic [7:0] OPC_NO_OVF     = 8'he5;
	localparam logic [7:0] OPC_NONZERO    = 8'he1;
	localparam logic [4:0] OPC_ALWAYS_REL = 5'h1a;
	localparam logic [3:0] OPC_SET_BIT    = 4'h8;

	// =========================================================
	// Instruction field positions
	localparam int OPC8_HI    = 15;
	localparam int OPC8_LO    = 8;
	localparam int OPC5_LO    = 11;
	localparam int OPC4_LO    = 12;
	localparam int BIT_IDX_HI = 11;
	localparam int BIT_IDX_LO = 9;
	localparam int ACC_FLAG   = 8;
	localparam int SHORT_W    = 8;
	localparam int LONG_W     = 11;

	// =========================================================
	// Program counter and data memory layout
	localparam int         PC_STEP         = 2;
	localparam int         BANK_W          = 4;
	localparam logic [7:0] ACCESS_SPLIT    = 8'h80;
	localparam logic [3:0] ACCESS_LO_BANK  = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK  = 4'hf;

	// =========================================================
	// Q phase encoding and reset values
	localparam logic [1:0] PHASE_Q1 = 2'h0;
	localparam logic [1:0] PHASE_Q2 = 2'h1;
	localparam logic [1:0] PHASE_Q3 = 2'h2;
	localparam logic [1:0] PHASE_Q4 = 2'h3;

	typedef enum logic [2:0] {OP_NONE, OP_NO_OVF, OP_NONZERO, OP_ALWAYS, OP_SET_BIT} bbs_op_e;
	typedef enum logic {ST_RUN, ST_FLUSH} bbs_state_e;

endpackage

// File: design/bbs_phase_if.sv
// Q1..Q4 phase strobes shared between the phase generator and the executor
`timescale 1ns/1ps
`default_nettype none
interface bbs_phase_if;
	logic q1;
	logic q2;
	logic q3;
	logic q4;
	modport gen (output q1, output q2, output q3, output q4);
	modport sink (input q1, input q2, input q3, input q4);
endinterface
`default_nettype wire

// File: design/bbs_qphase.sv
// Four-phase instruction cycle generator
`timescale 1ns/1ps
`default_nettype none
module bbs_qphase
	import bbs_pkg::*;
(
	// Clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_reset_n,
	// Phase strobes
	bbs_phase_if.gen  ph
);
	logic [1:0] phase_ff;

	always_ff @(posedge i_core_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			phase_ff <= PHASE_Q1;
		else
			phase_ff <= phase_ff + 2'h1;
	end

	assign ph.q1 = (phase_ff == PHASE_Q1);
	assign ph.q2 = (phase_ff == PHASE_Q2);
	assign ph.q3 = (phase_ff == PHASE_Q3);
	assign ph.q4 = (phase_ff == PHASE_Q4);
endmodule
`default_nettype wire

// File: test/bbs_mem_model.sv
// Data memory model answering the bit-set read one clock after the strobe
`timescale 1ns/1ps
`default_nettype none
module bbs_mem_model (
	// Clock
	input  wire logic        i_core_clk,
	// Memory port
	input  wire logic        i_rd,
	input  wire logic        i_wr,
	input  wire logic [11:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	output logic      [7:0]  o_rdata
);
	logic [7:0] mem [4096];
	initial begin
		for (int a = 0; a < 4096; a++) mem[a] = 8'(a) ^ {2{4'(a >> 8)}} ^ 8'h5a;
		o_rdata = 8'h00;
	end
	// Bus toggles outside the answer clock so stale data never passes
	always @(posedge i_core_clk) begin
		o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
		if (i_wr) mem[i_addr] <= i_wdata;
	end
endmodule
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the branch and bit-set decoder
`timescale 1ns/1ps
`default_nettype none
module tb;
	import bbs_pkg::*;
	typedef struct packed {
		logic [15:0] instr;
		logic [20:0] pc;
		logic        ovf;
		logic        zero;
		logic [3:0]  bank;
		logic        ld;
		logic [20:0] tgt;
		logic        wr;
		logic [11:0] addr;
	} bbs_row_s;
	// ==========
	// Signals
	logic i_core_clk, i_reset_n, i_instr_valid, i_flag_ovf, i_flag_zero;
	logic [15:0] i_instr;
	logic [20:0] i_instr_pc;
	logic [3:0] i_bank_select;
	logic [7:0] i_mem_rdata;
	wire o_instr_ready, o_flush, o_pc_load, o_mem_rd, o_mem_wr;
	wire [20:0] o_pc_target;
	wire [11:0] o_mem_addr;
	wire [7:0] o_mem_wdata;
	int err_total = 0;
	int cmp_count = 0;
	int cyc = 0;
	bbs_row_s rows [11] = '{
		'{16'he505, 21'h0_0100, 1'b0, 1'b1, 4'h0, 1'b1, 21'h0_010c, 1'b0, 12'h000},
		'{16'he505, 21'h0_0100, 1'b1, 1'b0, 4'h0, 1'b0, 21'h0_0000, 1'b0, 12'h000},
		'{16'he180, 21'h0_1000, 1'b1, 1'b0, 4'h0, 1'b1, 21'h0_0f02, 1'b0, 12'h000},
		'{16'he17f, 21'h0_1000, 1'b0, 1'b1, 4'h0, 1'b0, 21'h0_0000, 1'b0, 12'h000},
		'{16'hd3ff, 21'h0_0200, 1'b1, 1'b1, 4'h0, 1'b1, 21'h0_0a00, 1'b0, 12'h000},
		'{16'hd400, 21'h1_0000, 1'b1, 1'b1, 4'h0, 1'b1, 21'h0_f802, 1'b0, 12'h000},
		'{16'he501, 21'h1f_fffe, 1'b0, 1'b0, 4'h0, 1'b1, 21'h0_0002, 1'b0, 12'h000},
		'{16'h8e7f, 21'h0_0300, 1'b0, 1'b0, 4'h5, 1'b0, 21'h0_0000, 1'b1, 12'h07f},
		'{16'h8080, 21'h0_0302, 1'b0, 1'b0, 4'h5, 1'b0, 21'h0_0000, 1'b1, 12'hf80},
		'{16'h8712, 21'h0_0304, 1'b0, 1'b0, 4'ha, 1'b0, 21'h0_0000, 1'b1, 12'ha12},
		'{16'he600, 21'h0_0306, 1'b0, 1'b0, 4'h0, 1'b0, 21'h0_0000, 1'b0, 12'h000}};
	// ==========
	// Design and memory
	bbs_decode_exec #(.PC_W(21)) bbs_decode_exec_inst (.i_core_clk(i_core_clk), .i_reset_n(i_reset_n),
		.i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_instr_pc(i_instr_pc), .o_instr_ready(o_instr_ready),
		.o_flush(o_flush), .i_flag_ovf(i_flag_ovf), .i_flag_zero(i_flag_zero), .i_bank_select(i_bank_select),
		.o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_mem_rd(o_mem_rd), .o_mem_wr(o_mem_wr),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_rdata(i_mem_rdata));
	bbs_mem_model bbs_mem_model_inst (.i_core_clk(i_core_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr),
		.i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));
	always #2 i_core_clk = ~i_core_clk;
	// ==========
	// Helpers
	function automatic logic [7:0] memv(input logic [11:0] a);
		return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5a;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic drive(input int n);
		i_instr_valid <= (n >= 0);
		if (n >= 0) begin
			i_instr <= rows[n].instr;
			i_instr_pc <= rows[n].pc;
			i_bank_select <= rows[n].bank;
		end
	endtask
	task automatic wait_rdy();
		#1;
		while (o_instr_ready !== 1'b1) begin
			@(posedge i_core_clk);
			#1;
		end
	endtask
	// Row i is on the inputs; its accept edge also offers row nx
	task automatic do_row(input int i, input int nx);
		int ld_k, wr_k, rd_k;
		logic [20:0] tgt;
		logic [11:0] ad;
		logic [7:0] wd;
		ld_k = 0;
		wr_k = 0;
		rd_k = 0;
		wait_rdy();
		@(posedge i_core_clk);
		i_flag_ovf <= rows[i].ovf;
		i_flag_zero <= rows[i].zero;
		drive(nx);
		for (int k = 1; k <= 4; k++) begin
			if (k > 1) @(posedge i_core_clk);
			#1;
			if (o_pc_load === 1'b1) begin
				ld_k = k;
				tgt = o_pc_target;
			end
			if (o_mem_rd === 1'b1) begin
				rd_k = k;
				ad = o_mem_addr;
			end
			if (o_mem_wr === 1'b1) begin
				wr_k = k;
				wd = o_mem_wdata;
			end
		end
		chk(ld_k, rows[i].ld ? 3 : 0);
		if (rows[i].ld) chk(tgt, rows[i].tgt);
		chk(o_flush, rows[i].ld);
		chk(o_instr_ready, !rows[i].ld);
		chk(rd_k, rows[i].wr ? 1 : 0);
		chk(wr_k, rows[i].wr ? 3 : 0);
		if (rows[i].wr) chk(ad, rows[i].addr);
		if (rows[i].wr) chk(wd, memv(rows[i].addr) | (8'h01 << rows[i].instr[11:9]));
		$display("row %0d done", i);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// ==========
	// Sequence
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 1000) begin
			err_total++;
			tally_and_finish();
		end
	end
	initial begin
		i_core_clk = 1'b0;
		i_reset_n = 1'b0;
		i_flag_ovf = 1'b0;
		i_flag_zero = 1'b0;
		i_instr_valid = 1'b1;
		i_instr = rows[0].instr;
		i_instr_pc = rows[0].pc;
		i_bank_select = rows[0].bank;
		// First edge under reset settles every register before the look
		@(posedge i_core_clk);
		#1;
		chk({o_instr_ready, o_flush, o_pc_load, o_mem_rd, o_mem_wr}, 5'h10);
		$display("reset check done");
		@(posedge i_core_clk);
		i_reset_n <= 1'b1;
		for (int i = 0; i < 11; i++) do_row(i, i < 10 ? i + 1 : -1);
		// Reset landing between accept and Q4 must drop the pending jump
		@(posedge i_core_clk);
		drive(0);
		wait_rdy();
		@(posedge i_core_clk);
		i_instr_valid <= 1'b0;
		i_flag_ovf <= 1'b0;
		@(posedge i_core_clk);
		i_reset_n <= 1'b0;
		repeat (3) begin
			@(posedge i_core_clk);
			#1;
			chk({o_instr_ready, o_flush, o_pc_load}, 3'h4);
		end
		@(posedge i_core_clk);
		i_reset_n <= 1'b1;
		drive(7);
		do_row(7, -1);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
